// >>> dv/bsd_regs_sva.sv
`timescale 1ns/1ns
module bsd_regs_sva
	import bsd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regWdata,
	input wire logic [31:0] regRdata,
	input wire logic regRdValid,
	// Watched settings and levels
	input wire logic [4:0] slotNum,
	input wire logic [19:0] storedBlocks,
	input wire logic blocksPresent,
	input wire logic genLoad,
	input wire logic [SEED_W-1:0] genSeed
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic [7:0] rdAddr_r;
	// Offset of the read being answered
	always_ff @(posedge clk) begin
		if (regRd) begin
			rdAddr_r <= regAddr;
		end
	end
	// Unused bits of an answered read stay low
	property zeroBits(logic [7:0] a, logic [31:0] m);
		regRdValid && rdAddr_r == a |-> (regRdata & m) == 32'h0000_0000;
	endproperty
	chk_seed_load_now: assert property (regWr && regAddr == OFS_SEED |=>
		genLoad && {2'b00, genSeed} == ($past(regWdata) & 32'h3FFF_FFFF)) else $error("seed write not loaded");
	chk_load_has_cause: assert property (genLoad |-> $past(regWr) && $past(regAddr) == OFS_SEED)
		else $error("load without seed write");
	chk_blocks_flag: assert property (!$past(srst) |-> blocksPresent == ($past(storedBlocks) != 20'h0_0000))
		else $error("block flag wrong");
	chk_slot_field: assert property (regRdValid && rdAddr_r == OFS_INTR |->
		regRdata[20:16] == $past(slotNum) && (regRdata & 32'hFF60_0000) == 32'h0000_0000) else $error("slot field wrong");
	chk_latency_flags: assert property (regRdValid && rdAddr_r == OFS_LATDLY |-> (regRdata & 32'h7000_7000) == 0
		&& regRdata[15] == (regRdata[11:0] != 12'h000) && regRdata[31] == (regRdata[27:16] != 12'h000))
		else $error("latency flags wrong");
	chk_block_upper: assert property (zeroBits(OFS_BLKSIZE, 32'hFFFF_0000)) else $error("block size upper set");
	chk_stable_upper: assert property (zeroBits(OFS_GENB, 32'hF000_0000)) else $error("stable upper set");
	chk_seed_upper: assert property (zeroBits(OFS_SEED, 32'hC000_0000)) else $error("seed upper set");
	chk_event_upper: assert property (zeroBits(OFS_EVTCNT, 32'hFF00_0000)) else $error("event upper set");
	// Main scenarios reached
	cov_gen_load: cover property (genLoad);
	cov_hist_read: cover property (regRdValid && rdAddr_r == OFS_HISTPAT);
	cov_blocks: cover property ($rose(blocksPresent));
endmodule
bind bsd_regs bsd_regs_sva chk (.clk, .srst, .regAddr, .regWr, .regRd, .regWdata, .regRdata, .regRdValid,
	.slotNum, .storedBlocks, .blocksPresent, .genLoad, .genSeed);

// >>> dv/bsd_regs_test.sv
`timescale 1ns/1ns
module bsd_regs_test
	import bsd_pkg::*;
;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} bsd_row_type;
	logic clk, srst, regWr, regRd, regRdValid, slotParityErr, acceptedEvent, secondTrigger, syncClear;
	logic stableWindow, patternMarker, pairMarker, spinState, procTick, trigIn, dataIn, trigDelayed;
	logic dataDelayed, testTrigSel, blocksPresent, genLoad, go, done;
	logic [7:0] regAddr, intVector, genDelay;
	logic [31:0] regWdata, regRdata, d;
	logic [4:0] slotNum;
	logic [2:0] intLevel;
	logic [15:0] blockSize, genSettle;
	logic [23:0] storedEvents;
	logic [19:0] storedBlocks;
	logic [SEED_W-1:0] recoveredShift, generatorShift, genSeed;
	logic [TESTDLY_W-1:0] testTrigDelay;
	logic [STABLE_W-1:0] genStable;
	bsd_mode_type genMode;
	int num_errors, num_checks, n, m, tn, dn;
	bsd_row_type rows[9] = '{'{OFS_INTR, 32'hFFFF_FFFF, 32'h008B_07FF}, '{OFS_BLKSIZE, 32'hFFFF_FFFF, 32'h0000_FFFF},
		'{OFS_LATDLY, 32'hFFFF_FFFF, 32'h8FFF_8FFF}, '{OFS_GENA, 32'hFFFF_FFFF, 32'hFFFF_FF03},
		'{OFS_GENB, 32'hFFFF_FFFF, 32'h0FFF_FFFF}, '{OFS_SEED, 32'hFFFF_FFFF, 32'h3FFF_FFFF},
		'{OFS_TEST, 32'h1234_5678, 32'h1234_5678}, '{8'h7C, 32'hFFFF_FFFF, 32'h0000_0000},
		'{OFS_ACCTOT, 32'hFFFF_FFFF, 32'h0000_0000}};
	logic [7:0] hAddr[8] = '{OFS_FALLCNT, OFS_RISECNT, OFS_PATCNT, OFS_PAIRCNT, OFS_HISTPAT, OFS_HISTPAIR,
		OFS_HISTSPIN, OFS_HISTSEQ};
	logic [31:0] hExp[8] = '{32'h8, 32'h8, 32'h2, 32'h4, 32'h88, 32'hAA, 32'h92, 32'h2};
	bsd_regs #(.CHK_CYCLES(8)) dut (.clk, .srst, .regAddr, .regWr, .regRd, .regWdata, .regRdata, .regRdValid,
		.slotNum, .slotParityErr, .acceptedEvent, .secondTrigger, .syncClear, .stableWindow, .patternMarker,
		.pairMarker, .spinState, .procTick, .storedEvents, .storedBlocks, .recoveredShift, .generatorShift,
		.trigIn, .dataIn, .trigDelayed, .dataDelayed, .testTrigSel, .intVector, .intLevel, .blockSize,
		.testTrigDelay, .blocksPresent, .genLoad, .genMode, .genDelay, .genSettle, .genStable, .genSeed);
	bsd_src_model src (.clk, .go, .done, .stableWindow, .patternMarker, .pairMarker, .spinState);
	// Clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge clk);
		#1;
		regAddr = a;
		regWdata = w;
		regWr = 1'b1;
		@(posedge clk);
		#1 regWr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		int k;
		@(posedge clk);
		#1;
		regAddr = a;
		regRd = 1'b1;
		@(posedge clk);
		#1 regRd = 1'b0;
		for (k = 0; k < 4 && regRdValid !== 1'b1; k++) @(posedge clk);
		if (k == 4) begin
			cmp("read answer", 32'h1, 32'h0);
			final_report();
		end else d = regRdata;
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		cmp(nm, e, d);
	endtask
	// Main sequence
	initial begin
		{srst, regWr, regRd, go, trigIn, dataIn, testTrigSel, acceptedEvent, secondTrigger, syncClear} = 10'h200;
		{regAddr, regWdata, storedEvents, storedBlocks} = 84'h0;
		{slotNum, slotParityErr, procTick} = 7'h2F;
		recoveredShift = 30'h1555_5555;
		generatorShift = 30'h2AAA_AAAA;
		repeat (4) @(posedge clk);
		#1 srst = 1'b0;
		rc("reset flags", OFS_LATDLY, 32'h0000_0000);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rc("row", rows[i].a, rows[i].e);
		end
		cmp("int setup", 32'h0000_07FF, {21'h0, intLevel, intVector});
		cmp("block size", 32'h0000_FFFF, {16'h0, blockSize});
		for (m = 0; m < 4; m++) begin
			wr(OFS_GENA, {16'h00C8, 8'h05, 6'h00, m[1:0]});
			wr(OFS_GENB, 32'h0000_0100);
			wr(OFS_SEED, 32'h2ABC_DEF1);
			@(posedge clk);
			#1 cmp("gen mode", {30'h0, m[1:0]}, {30'h0, genMode});
		end
		wr(OFS_GENA, 32'h0000_0000);
		cmp("gen timing", 32'h00C8_0005, {genSettle, 8'h00, genDelay});
		cmp("gen stable", 32'h0000_0100, {4'h0, genStable});
		cmp("gen seed", 32'h2ABC_DEF1, {2'b00, genSeed});
		cmp("test delay off", 32'h0000_0000, {14'h0, testTrigDelay});
		testTrigSel = 1'b1;
		repeat (3) @(posedge clk);
		#1 cmp("test delay", 32'h0000_5678, {14'h0, testTrigDelay});
		for (n = 0; n < 3; n++) begin
			{acceptedEvent, secondTrigger, syncClear} = {1'b1, n < 2, n == 0};
			@(posedge clk);
			#1 {acceptedEvent, secondTrigger, syncClear} = 3'h0;
		end
		rc("accepted", OFS_ACCTOT, 32'h0000_0003);
		rc("second", OFS_TRG2TOT, 32'h0000_0002);
		rc("sync clear", OFS_SYNCTOT, 32'h0000_0001);
		storedEvents = 24'hAB_CDEF;
		storedBlocks = 20'h0_0005;
		rc("events", OFS_EVTCNT, 32'h00AB_CDEF);
		rc("blocks", OFS_BLKCNT, 32'h0000_0005);
		cmp("blocks flag", 32'h1, {31'h0, blocksPresent});
		rc("recovered", OFS_RECSHIFT, 32'h1555_5555);
		generatorShift = 30'h0000_0000;
		rc("generator", OFS_GENSHIFT, 32'h2AAA_AAAA);
		wr(OFS_CLKCHK, 32'h0000_0000);
		repeat (4) @(posedge clk);
		#1 procTick = 1'b0;
		repeat (8) @(posedge clk);
		rc("clock check", OFS_CLKCHK, 32'h0000_0004);
		go = 1'b1;
		for (n = 0; n < 200 && done !== 1'b1; n++) @(posedge clk);
		cmp("windows done", 32'h1, {31'h0, done});
		if (done !== 1'b1) final_report();
		foreach (hAddr[i]) rc("window", hAddr[i], hExp[i]);
		wr(OFS_LATDLY, 32'h0005_0003);
		rc("delays", OFS_LATDLY, 32'h8005_8003);
		{trigIn, dataIn, tn, dn} = {2'b11, 64'h0};
		for (n = 1; n <= 12; n++) begin
			@(posedge clk);
			#1 {trigIn, dataIn} = 2'b00;
			if (trigDelayed === 1'b1 && tn == 0) tn = n;
			if (dataDelayed === 1'b1 && dn == 0) dn = n;
		end
		cmp("trig delay", 32'h4, tn);
		cmp("data delay", 32'h6, dn);
		rd(OFS_LATCHK);
		cmp("lat confirm", 32'h3, {20'h0, d[27:16] - d[11:0]});
		rd(OFS_DATCHK);
		cmp("dat confirm", 32'h5, {20'h0, d[27:16] - d[11:0]});
		srst = 1'b1;
		repeat (2) @(posedge clk);
		#1 srst = 1'b0;
		rc("reset size", OFS_BLKSIZE, 32'h0000_0000);
		final_report();
	end
endmodule

// >>> dv/bsd_src_model.sv
`timescale 1ns/1ns
module bsd_src_model #(
	parameter int WINDOWS = 8
) (
	// Clock
	input wire logic clk,
	// Start and completion
	input wire logic go,
	output logic done,
	// Window signals
	output logic stableWindow,
	output logic patternMarker,
	output logic pairMarker,
	output logic spinState
);
	// Quartet windows; markers settle while the window is closed
	initial begin
		done = 1'b0;
		stableWindow = 1'b0;
		patternMarker = 1'b0;
		pairMarker = 1'b0;
		spinState = 1'b0;
		wait (go === 1'b1);
		for (int k = 0; k < WINDOWS; k++) begin
			@(posedge clk);
			#1;
			stableWindow = 1'b0;
			patternMarker = (k % 4 == 0);
			pairMarker = (k % 2 == 0);
			spinState = (k % 3 == 0);
			repeat (2) @(posedge clk);
			#1 stableWindow = 1'b1;
			repeat (5) @(posedge clk);
		end
		@(posedge clk);
		#1 stableWindow = 1'b0;
		done = 1'b1;
	end
endmodule

// >>> hw/bsd_pkg.sv
package bsd_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_INTR = 8'h14;
	localparam logic [7:0] OFS_BLKSIZE = 8'h18;
	localparam logic [7:0] OFS_LATDLY = 8'h1C;
	localparam logic [7:0] OFS_GENA = 8'h20;
	localparam logic [7:0] OFS_GENB = 8'h24;
	localparam logic [7:0] OFS_SEED = 8'h28;
	localparam logic [7:0] OFS_TEST = 8'h2C;
	localparam logic [7:0] OFS_ACCTOT = 8'h30;
	localparam logic [7:0] OFS_TRG2TOT = 8'h34;
	localparam logic [7:0] OFS_SYNCTOT = 8'h38;
	localparam logic [7:0] OFS_EVTCNT = 8'h3C;
	localparam logic [7:0] OFS_BLKCNT = 8'h40;
	localparam logic [7:0] OFS_FALLCNT = 8'h44;
	localparam logic [7:0] OFS_RISECNT = 8'h48;
	localparam logic [7:0] OFS_PATCNT = 8'h4C;
	localparam logic [7:0] OFS_PAIRCNT = 8'h50;
	localparam logic [7:0] OFS_CLKCHK = 8'h54;
	localparam logic [7:0] OFS_RECSHIFT = 8'h58;
	localparam logic [7:0] OFS_GENSHIFT = 8'h5C;
	localparam logic [7:0] OFS_LATCHK = 8'h60;
	localparam logic [7:0] OFS_DATCHK = 8'h64;
	localparam logic [7:0] OFS_HISTPAT = 8'h68;
	localparam logic [7:0] OFS_HISTPAIR = 8'h6C;
	localparam logic [7:0] OFS_HISTSPIN = 8'h70;
	localparam logic [7:0] OFS_HISTSEQ = 8'h74;
	// Field positions
	localparam int INTR_LVL_LSB = 8;
	localparam int INTR_SLOT_LSB = 16;
	localparam int INTR_PAR_BIT = 23;
	localparam int LAT_CFG_BIT = 15;
	localparam int DLY_LSB = 16;
	localparam int DLY_CFG_BIT = 31;
	localparam int GEN_DELAY_LSB = 8;
	localparam int GEN_SETTLE_LSB = 16;
	localparam int CONF_WR_LSB = 16;
	// Field widths
	localparam int DLY_W = 12;
	localparam int SEED_W = 30;
	localparam int STABLE_W = 28;
	localparam int TESTDLY_W = 18;
	// Reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// Pattern mode encodings
	typedef enum logic [1:0] {
		MODE_PAIR = 2'h0,
		MODE_QUARTET = 2'h1,
		MODE_OCTET = 2'h2,
		MODE_TOGGLE = 2'h3
	} bsd_mode_type;
	// Clock check timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int CLKCHK_WINDOW_NS = 10240;
	localparam int CLKCHK_CYCLES = CLKCHK_WINDOW_NS / CLK_PERIOD_NS;
endpackage

// >>> hw/bsd_regs.sv
`timescale 1ns/1ns
module bsd_regs
	import bsd_pkg::*;
#(
	parameter int DEPTH = 4096,
	parameter int CHK_CYCLES = CLKCHK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regWdata,
	output logic [31:0] regRdata,
	output logic regRdValid,
	// Chassis slot
	input wire logic [4:0] slotNum,
	input wire logic slotParityErr,
	// Decoder events and levels
	input wire logic acceptedEvent,
	input wire logic secondTrigger,
	input wire logic syncClear,
	input wire logic stableWindow,
	input wire logic patternMarker,
	input wire logic pairMarker,
	input wire logic spinState,
	input wire logic procTick,
	input wire logic [23:0] storedEvents,
	input wire logic [19:0] storedBlocks,
	input wire logic [SEED_W-1:0] recoveredShift,
	input wire logic [SEED_W-1:0] generatorShift,
	// Delay lines
	input wire logic trigIn,
	input wire logic dataIn,
	output logic trigDelayed,
	output logic dataDelayed,
	// Settings to the decoder
	input wire logic testTrigSel,
	output logic [7:0] intVector,
	output logic [2:0] intLevel,
	output logic [15:0] blockSize,
	output logic [TESTDLY_W-1:0] testTrigDelay,
	output logic blocksPresent,
	// Generator load
	output logic genLoad,
	output bsd_mode_type genMode,
	output logic [7:0] genDelay,
	output logic [15:0] genSettle,
	output logic [STABLE_W-1:0] genStable,
	output logic [SEED_W-1:0] genSeed
);
	// Delay memory address width
	localparam int AW = $clog2(DEPTH);

	// Pack read and write addresses
	function automatic logic [31:0] confWord(input logic [AW-1:0] rd, input logic [AW-1:0] wr);
		logic [31:0] w;
		w = RST_WORD;
		w[AW-1:0] = rd;
		w[CONF_WR_LSB +: AW] = wr;
		return w;
	endfunction

	// Setup words and configured flags
	logic [31:0] intr_r, blk_r, latDly_r, genA_r, genB_r, seed_r, test_r;
	logic latCfg_r, dlyCfg_r;
	// Totals, edge scalers and their snapshots
	logic [31:0] accTot_r, trg2Tot_r, syncTot_r;
	logic [31:0] fallCnt_r, riseCnt_r, patCnt_r, pairCnt_r;
	logic [31:0] riseSnap_r, patSnap_r, pairSnap_r;
	logic stablePrev_r, patPrev_r, pairPrev_r;
	// Clock check and generator capture
	logic [31:0] chkCnt_r, chkTimer_r;
	logic chkRun_r;
	logic [SEED_W-1:0] genSnap_r;
	// Delay write address, latched word, window history
	logic [AW-1:0] wrAddr_r;
	logic [31:0] datConf_r;
	logic [31:0] hPat_r, hPair_r, hSpin_r, hSeq_r;
	logic [31:0] sPair_r, sSpin_r, sSeq_r;
	// Delay memories and read addresses
	logic trigMem [DEPTH];
	logic dataMem [DEPTH];
	logic [AW-1:0] latRd, datRd;
	logic wrEn, rdEn, windowStart;

	// Strobes, window start, memory read addresses
	assign wrEn = regWr;
	assign rdEn = regRd;
	assign windowStart = stableWindow && !stablePrev_r;
	assign latRd = wrAddr_r - latDly_r[AW-1:0];
	assign datRd = wrAddr_r - latDly_r[DLY_LSB +: AW];

	// Writable setup registers
	always_ff @(posedge clk) begin
		if (srst) begin
			intr_r <= RST_WORD;
			blk_r <= RST_WORD;
			genA_r <= RST_WORD;
			genB_r <= RST_WORD;
			seed_r <= RST_WORD;
			test_r <= RST_WORD;
		end else if (wrEn) begin
			unique case (regAddr)
				OFS_INTR: intr_r <= {21'h00_0000, regWdata[10:0]};
				OFS_BLKSIZE: blk_r <= {16'h0000, regWdata[15:0]};
				OFS_GENA: genA_r <= {regWdata[31:8], 6'h00, regWdata[1:0]};
				OFS_GENB: genB_r <= {4'h0, regWdata[STABLE_W-1:0]};
				OFS_SEED: seed_r <= {2'h0, regWdata[SEED_W-1:0]};
				OFS_TEST: test_r <= regWdata;
				default: ;
			endcase
		end
	end

	// Latency and data delay with configured flags
	always_ff @(posedge clk) begin
		if (srst) begin
			latDly_r <= RST_WORD;
			latCfg_r <= 1'b0;
			dlyCfg_r <= 1'b0;
		end else if (wrEn && regAddr == OFS_LATDLY) begin
			latDly_r <= {4'h0, regWdata[DLY_LSB +: DLY_W], 4'h0, regWdata[DLY_W-1:0]};
			latCfg_r <= regWdata[DLY_W-1:0] != 12'h000;
			dlyCfg_r <= regWdata[DLY_LSB +: DLY_W] != 12'h000;
		end
	end

	// Seed write hands all generator fields over at once
	always_ff @(posedge clk) begin
		if (srst) begin
			genLoad <= 1'b0;
			genMode <= MODE_PAIR;
			genDelay <= 8'h00;
			genSettle <= 16'h0000;
			genStable <= '0;
			genSeed <= '0;
		end else begin
			genLoad <= wrEn && regAddr == OFS_SEED;
			if (wrEn && regAddr == OFS_SEED) begin
				genMode <= bsd_mode_type'(genA_r[1:0]);
				genDelay <= genA_r[GEN_DELAY_LSB +: 8];
				genSettle <= genA_r[GEN_SETTLE_LSB +: 16];
				genStable <= genB_r[STABLE_W-1:0];
				genSeed <= regWdata[SEED_W-1:0];
			end
		end
	end

	// Settings driven out to the decoder
	always_ff @(posedge clk) begin
		if (srst) begin
			intVector <= 8'h00;
			intLevel <= 3'h0;
			blockSize <= 16'h0000;
			testTrigDelay <= '0;
			blocksPresent <= 1'b0;
		end else begin
			intVector <= intr_r[7:0];
			intLevel <= intr_r[INTR_LVL_LSB +: 3];
			blockSize <= blk_r[15:0];
			testTrigDelay <= testTrigSel ? test_r[TESTDLY_W-1:0] : '0;
			blocksPresent <= storedBlocks != 20'h0_0000;
		end
	end

	// Event totals, wrapping
	always_ff @(posedge clk) begin
		if (srst) begin
			accTot_r <= RST_WORD;
			trg2Tot_r <= RST_WORD;
			syncTot_r <= RST_WORD;
		end else begin
			if (acceptedEvent)
				accTot_r <= accTot_r + 32'h0000_0001;
			if (secondTrigger)
				trg2Tot_r <= trg2Tot_r + 32'h0000_0001;
			if (syncClear)
				syncTot_r <= syncTot_r + 32'h0000_0001;
		end
	end

	// Edge scalers of stable window and markers
	always_ff @(posedge clk) begin
		if (srst) begin
			stablePrev_r <= 1'b0;
			patPrev_r <= 1'b0;
			pairPrev_r <= 1'b0;
			fallCnt_r <= RST_WORD;
			riseCnt_r <= RST_WORD;
			patCnt_r <= RST_WORD;
			pairCnt_r <= RST_WORD;
		end else begin
			stablePrev_r <= stableWindow;
			patPrev_r <= patternMarker;
			pairPrev_r <= pairMarker;
			if (!stableWindow && stablePrev_r)
				fallCnt_r <= fallCnt_r + 32'h0000_0001;
			if (windowStart)
				riseCnt_r <= riseCnt_r + 32'h0000_0001;
			if (patternMarker && !patPrev_r)
				patCnt_r <= patCnt_r + 32'h0000_0001;
			if (pairMarker && !pairPrev_r)
				pairCnt_r <= pairCnt_r + 32'h0000_0001;
		end
	end

	// Snapshot taken when the falling scaler is read
	always_ff @(posedge clk) begin
		if (srst) begin
			riseSnap_r <= RST_WORD;
			patSnap_r <= RST_WORD;
			pairSnap_r <= RST_WORD;
		end else if (rdEn && regAddr == OFS_FALLCNT) begin
			riseSnap_r <= riseCnt_r;
			patSnap_r <= patCnt_r;
			pairSnap_r <= pairCnt_r;
		end
	end

	// Clock check: count processing ticks over fixed window
	always_ff @(posedge clk) begin
		if (srst) begin
			chkRun_r <= 1'b0;
			chkCnt_r <= RST_WORD;
			chkTimer_r <= RST_WORD;
		end else if (wrEn && regAddr == OFS_CLKCHK) begin
			chkRun_r <= 1'b1;
			chkCnt_r <= RST_WORD;
			chkTimer_r <= 32'(CHK_CYCLES);
		end else if (chkRun_r) begin
			if (procTick)
				chkCnt_r <= chkCnt_r + 32'h0000_0001;
			chkTimer_r <= chkTimer_r - 32'h0000_0001;
			if (chkTimer_r == 32'h0000_0001)
				chkRun_r <= 1'b0;
		end
	end

	// Generator value captured with recovered read
	always_ff @(posedge clk) begin
		if (srst)
			genSnap_r <= '0;
		else if (rdEn && regAddr == OFS_RECSHIFT)
			genSnap_r <= generatorShift;
	end

	// Delay memories, addressed modulo depth
	always_ff @(posedge clk) begin
		if (srst) begin
			wrAddr_r <= '0;
			trigDelayed <= 1'b0;
			dataDelayed <= 1'b0;
		end else begin
			wrAddr_r <= wrAddr_r + AW'(1);
			trigDelayed <= trigMem[latRd];
			dataDelayed <= dataMem[datRd];
		end
	end

	// Memory write ports
	always_ff @(posedge clk) begin
		trigMem[wrAddr_r] <= trigIn;
		dataMem[wrAddr_r] <= dataIn;
	end

	// Data delay word captured by latency read
	always_ff @(posedge clk) begin
		if (srst) begin
			datConf_r <= RST_WORD;
		end else if (rdEn && regAddr == OFS_LATCHK) begin
			datConf_r <= confWord(datRd, wrAddr_r);
		end
	end

	// Per-window history shift registers, newest in bit 0; hSeq_r shifts only in windows with patternMarker set
	always_ff @(posedge clk) begin
		if (srst) begin
			hPat_r <= RST_WORD;
			hPair_r <= RST_WORD;
			hSpin_r <= RST_WORD;
			hSeq_r <= RST_WORD;
		end else if (windowStart) begin
			hPat_r <= {hPat_r[30:0], patternMarker};
			hPair_r <= {hPair_r[30:0], pairMarker};
			hSpin_r <= {hSpin_r[30:0], spinState};
			if (patternMarker)
				hSeq_r <= {hSeq_r[30:0], spinState};
		end
	end

	// History snapshot on pattern history (OFS_HISTPAT) read
	always_ff @(posedge clk) begin
		if (srst) begin
			sPair_r <= RST_WORD;
			sSpin_r <= RST_WORD;
			sSeq_r <= RST_WORD;
		end else if (rdEn && regAddr == OFS_HISTPAT) begin
			sPair_r <= hPair_r;
			sSpin_r <= hSpin_r;
			sSeq_r <= hSeq_r;
		end
	end

	// Read data mux, answered one cycle after the strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			regRdata <= RST_WORD;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= rdEn;
			if (rdEn) begin
				unique case (regAddr)
					OFS_INTR: regRdata <= {8'h00, slotParityErr, 2'h0, slotNum, 5'h00, intr_r[10:0]};
					OFS_BLKSIZE: regRdata <= blk_r;
					OFS_LATDLY: regRdata <= {dlyCfg_r, latDly_r[30:16], latCfg_r, latDly_r[14:0]};
					OFS_GENA: regRdata <= genA_r;
					OFS_GENB: regRdata <= genB_r;
					OFS_SEED: regRdata <= seed_r;
					OFS_TEST: regRdata <= test_r;
					OFS_ACCTOT: regRdata <= accTot_r;
					OFS_TRG2TOT: regRdata <= trg2Tot_r;
					OFS_SYNCTOT: regRdata <= syncTot_r;
					OFS_EVTCNT: regRdata <= {8'h00, storedEvents};
					OFS_BLKCNT: regRdata <= {12'h000, storedBlocks};
					OFS_FALLCNT: regRdata <= fallCnt_r;
					OFS_RISECNT: regRdata <= riseSnap_r;
					OFS_PATCNT: regRdata <= patSnap_r;
					OFS_PAIRCNT: regRdata <= pairSnap_r;
					OFS_CLKCHK: regRdata <= chkCnt_r;
					OFS_RECSHIFT: regRdata <= {2'h0, recoveredShift};
					OFS_GENSHIFT: regRdata <= {2'h0, genSnap_r};
					OFS_LATCHK: regRdata <= confWord(latRd, wrAddr_r);
					OFS_DATCHK: regRdata <= datConf_r;
					OFS_HISTPAT: regRdata <= hPat_r;
					OFS_HISTPAIR: regRdata <= sPair_r;
					OFS_HISTSPIN: regRdata <= sSpin_r;
					OFS_HISTSEQ: regRdata <= sSeq_r;
					default: regRdata <= RST_WORD;
				endcase
			end
		end
	end
endmodule
